// [bench/boot_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module boot_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic port_b_top_pin,
  input wire logic [7:0] data_port_oe,
  input wire logic emu_mode,
  input wire logic boot_mode,
  input wire logic boot_rom_map_enable,
  input wire logic [15:0] cpu_addr,
  input wire logic boot_rom_sel,
  input wire logic [9:0] load_count,
  input wire logic loading,
  input wire logic exec_go,
  input wire logic [15:0] exec_addr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_exec_sticky: assert property (exec_go |=> exec_go) else $error("start dropped");
  a_exec_target: assert property (exec_go |-> exec_addr == 16'h0000 || exec_addr == 16'hb600)
    else $error("bad start address");
  a_rom_select: assert property (!$past(sys_rst) |-> boot_rom_sel ==
    ($past(boot_rom_map_enable) && $past(cpu_addr[15:8]) == 8'hbf)) else $error("boot rom select wrong");
  a_map_locked: assert property (!boot_mode |-> !boot_rom_map_enable) else $error("map bit set");
  // Emulation lives inside reset, so this one must not be masked by it
  a_pins_float: assert property (disable iff (1'b0) port_b_top_pin [*4] |-> data_port_oe == 8'h00)
    else $error("data pins driven");
  a_emu_exit: assert property ($fell(sys_rst) |=> !emu_mode) else $error("emulation after reset");
  a_idle_done: assert property (exec_go |-> !loading) else $error("loading after end");
  a_count_cap: assert property (load_count <= 10'h200) else $error("count over size");
  a_count_step: assert property (!$past(sys_rst) |-> load_count == $past(load_count) ||
    load_count == $past(load_count) + 10'h001) else $error("count skipped");
  a_count_frozen: assert property (exec_go |=> $stable(load_count)) else $error("stored after end");
endmodule // boot_sva
bind serial_boot_download boot_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .port_b_top_pin(port_b_top_pin),
  .data_port_oe(data_port_oe), .emu_mode(emu_mode), .boot_mode(boot_mode),
  .boot_rom_map_enable(boot_rom_map_enable), .cpu_addr(cpu_addr), .boot_rom_sel(boot_rom_sel),
  .load_count(load_count), .loading(loading), .exec_go(exec_go), .exec_addr(exec_addr));
`default_nettype wire

// [bench/host_uart.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_boot_defines.vh"
module host_uart (
  input wire logic ref_clk,
  input wire logic txd_line,
  input wire logic loop_en,
  output logic rxd
);
  logic drv = 1'b1;
  logic [7:0] sh;
  logic [7:0] echo_q[$];
  // Loopback feeds the break back as a first character
  assign rxd = loop_en ? txd_line : drv;
  // Characters go back to back, never waiting on the echo
  task automatic send_byte(input logic [7:0] b, input int bit_cyc);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drv = fr[i];
      repeat (bit_cyc) @(negedge ref_clk);
    end
  endtask
  // Echo decoder, fast rate only, mid-bit sampling
  initial begin
    forever begin
      @(negedge txd_line);
      repeat (`DIV_FAST + `DIV_FAST / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        sh[i] = txd_line;
        repeat (`DIV_FAST) @(posedge ref_clk);
      end
      echo_q.push_back(sh);
      wait (txd_line);
    end
  end
endmodule // host_uart
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_boot_defines.vh"
module tb_top;
  logic ref_clk = 0, sys_rst = 1, mode_a = 0, mode_b = 0, loop_en = 0;
  logic port_b_top_pin = 1, map_wr_en = 0, map_wr_data = 0;
  logic [7:0] data_port_in = 8'h00, eprom_rd_data = 8'h00;
  logic [15:0] cpu_addr = 16'h0000;
  logic [8:0] ram_rd_addr = 9'h000;
  wire rxd, txd_out, txd_oe, emu_mode, boot_rom_map_enable, boot_rom_sel, boot_mode, loading, exec_go;
  wire [7:0] data_port_out, data_port_oe, emu_wr_data, ram_rd_data;
  wire [2:0] rate_sel;
  wire [9:0] load_count;
  wire [15:0] exec_addr;
  // Open drain with pull-up
  wire txd_line = !txd_oe;
  int errors = 0, checks = 0;
  initial forever #50 ref_clk = ~ref_clk;
  serial_boot_download dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .mode_a(mode_a), .mode_b(mode_b),
    .rxd(rxd), .txd_out(txd_out), .txd_oe(txd_oe), .port_b_top_pin(port_b_top_pin),
    .data_port_in(data_port_in), .data_port_out(data_port_out), .data_port_oe(data_port_oe),
    .eprom_rd_data(eprom_rd_data), .emu_wr_data(emu_wr_data), .emu_mode(emu_mode),
    .map_wr_en(map_wr_en), .map_wr_data(map_wr_data), .boot_rom_map_enable(boot_rom_map_enable),
    .cpu_addr(cpu_addr), .boot_rom_sel(boot_rom_sel), .ram_rd_addr(ram_rd_addr), .ram_rd_data(ram_rd_data),
    .boot_mode(boot_mode), .rate_sel(rate_sel), .load_count(load_count), .loading(loading),
    .exec_go(exec_go), .exec_addr(exec_addr));
  host_uart host (.ref_clk(ref_clk), .txd_line(txd_line), .loop_en(loop_en), .rxd(rxd));
  // ----
  // Helpers
  // ----
  task check_eq(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task do_reset(input logic a, input logic b);
    @(negedge ref_clk);
    sys_rst = 1;
    mode_a = a;
    mode_b = b;
    repeat (20) @(negedge ref_clk);
    sys_rst = 0;
    // Line synchroniser and loader start need a few cycles before a character
    repeat (4) @(negedge ref_clk);
  endtask
  task wait_go(input int lim);
    int n;
    n = 0;
    while (exec_go !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= lim) begin
      errors++;
      tally_and_finish;
    end
  endtask
  task write_map(input logic v);
    map_wr_data = v;
    map_wr_en = 1;
    @(negedge ref_clk);
    map_wr_en = 0;
    @(negedge ref_clk);
  endtask
  // ----
  // Scenarios
  // ----
  task test_emulation;
    @(negedge ref_clk);
    sys_rst = 1;
    port_b_top_pin = 0;
    eprom_rd_data = 8'h96;
    data_port_in = 8'h3c;
    repeat (6) @(negedge ref_clk);
    check_eq(emu_mode, 1);
    check_eq(data_port_oe, 8'hff);
    check_eq(data_port_out, 8'h96);
    check_eq(emu_wr_data, 8'h3c);
    port_b_top_pin = 1;
    repeat (5) @(negedge ref_clk);
    check_eq(data_port_oe, 8'h00);
    mode_a = 1;
    repeat (5) @(negedge ref_clk);
    check_eq(emu_mode, 0);
    $display("test_emulation done");
  endtask
  task test_map;
    logic [15:0] a[4];
    logic e[4];
    a = '{16'hbf00, 16'hbfff, 16'hbeff, 16'hc000};
    e = '{1'b1, 1'b1, 1'b0, 1'b0};
    do_reset(0, 0);
    check_eq(boot_mode, 1);
    check_eq(boot_rom_map_enable, 1);
    for (int i = 0; i < 4; i++) begin
      cpu_addr = a[i];
      @(negedge ref_clk);
      check_eq(boot_rom_sel, e[i]);
    end
    cpu_addr = 16'hbf00;
    write_map(0);
    check_eq(boot_rom_map_enable, 0);
    check_eq(boot_rom_sel, 0);
    do_reset(1, 0);
    check_eq(boot_mode, 0);
    check_eq(boot_rom_map_enable, 0);
    write_map(1);
    check_eq(boot_rom_map_enable, 0);
    $display("test_map done");
  endtask
  task test_break;
    int n, k;
    n = 0;
    k = 0;
    loop_en = 1;
    do_reset(0, 0);
    while (!txd_oe && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    while (txd_oe && k < 4000) begin
      @(negedge ref_clk);
      k++;
    end
    if (n >= 1000 || k >= 4000) begin
      errors++;
      tally_and_finish;
    end
    check_eq(k, `DIV_FAST * 10);
    check_eq(txd_out, 0);
    wait_go(3000);
    check_eq(exec_addr, `EEPROM_START);
    check_eq(load_count, 0);
    loop_en = 0;
    $display("test_break done");
  endtask
  task test_rates;
    logic [7:0] c[5];
    int d[5];
    logic [2:0] r[5];
    c = '{8'hff, 8'hff, 8'hf0, 8'hfd, 8'hfd};
    d = '{`DIV_FAST, `DIV_SLOW, `DIV_ALT_A, `DIV_ALT_B, `DIV_ALT_C};
    r = '{`RATE_FAST, `RATE_SLOW, `RATE_ALT_A, `RATE_ALT_B, `RATE_ALT_C};
    for (int i = 0; i < 5; i++) begin
      do_reset(0, 0);
      host.send_byte(c[i], d[i]);
      check_eq(rate_sel, r[i]);
    end
    // Sync alone at the 4.9 character rate: empty load, then a jump to RAM
    do_reset(0, 0);
    host.send_byte(8'hf0, `DIV_ALT_A);
    repeat (`DIV_ALT_A * 47) @(negedge ref_clk);
    check_eq(exec_go, 0);
    wait_go(600);
    check_eq(exec_addr, `RAM_START);
    check_eq(load_count, 0);
    $display("test_rates done");
  endtask
  task test_download;
    logic [7:0] dat[4];
    dat = '{8'h5a, 8'hc3, 8'h00, 8'hff};
    do_reset(0, 0);
    // Long idle before the sync must not end anything
    repeat (12000) @(negedge ref_clk);
    check_eq(exec_go, 0);
    host.echo_q.delete();
    host.send_byte(8'hff, `DIV_FAST);
    for (int i = 0; i < 4; i++) host.send_byte(dat[i], `DIV_FAST);
    // With the pipeline kept full each echo must be out two characters after its byte
    repeat (`DIV_FAST * 20) @(negedge ref_clk);
    check_eq(host.echo_q.size(), 4);
    repeat (`DIV_FAST * 18) @(negedge ref_clk);
    check_eq(exec_go, 0);
    wait_go(4000);
    check_eq(exec_addr, `RAM_START);
    check_eq(loading, 0);
    check_eq(load_count, 4);
    for (int i = 0; i < 4; i++) begin
      ram_rd_addr = i;
      @(negedge ref_clk);
      check_eq(ram_rd_data, dat[i]);
      check_eq(host.echo_q[host.echo_q.size() - 4 + i], dat[i]);
    end
    $display("test_download done");
  endtask
  initial begin
    test_emulation;
    test_map;
    test_break;
    test_rates;
    test_download;
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire

// [hdl/boot_ram.v]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Program RAM, registered read
// ----------------------------------------
module boot_ram (
  input wire ref_clk,
  input wire wr_en,
  input wire [8:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [8:0] rd_addr,
  output reg [7:0] rd_data
);

  reg [7:0] mem [0:511];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // boot_ram

`default_nettype wire

// [hdl/serial_boot_defines.vh]
`ifndef SERIAL_BOOT_DEFINES_VH
`define SERIAL_BOOT_DEFINES_VH

// ----------------------------------------
// Memory map
// ----------------------------------------
`define RAM_START 16'h0000
`define EEPROM_START 16'hb600
`define RAM_BYTES 10'h200
`define BOOT_ROM_BASE 16'hbf00
`define BOOT_ROM_LAST 16'hbfff

// ----------------------------------------
// Bit periods in clock cycles, scaled with the clock
// ----------------------------------------
`define DIV_FAST 12'h100
`define DIV_SLOW 12'h683
`define DIV_ALT_A 12'h0d0
`define DIV_ALT_B 12'h180
`define DIV_ALT_C 12'h200

// ----------------------------------------
// Idle timeouts in bit times (ten bits a character)
// ----------------------------------------
`define TMO_FAST 8'h28
`define TMO_SLOW 8'h28
`define TMO_ALT_A 8'h31
`define TMO_ALT_B 8'had
`define TMO_ALT_C 8'h82

// ----------------------------------------
// Rate codes
// ----------------------------------------
`define RATE_FAST 3'h0
`define RATE_SLOW 3'h1
`define RATE_ALT_A 3'h2
`define RATE_ALT_B 3'h3
`define RATE_ALT_C 3'h4

// ----------------------------------------
// Sync pulse classification, low time in cycles
// ----------------------------------------
`define THR_B_FAST 12'h140
`define THR_C_B 12'h1c0
`define THR_A_C 12'h308
`define THR_SLOW_A 12'h549
`define THR_ZERO 12'h7d0

`define CHAR_BITS 4'ha

`endif

// [hdl/serial_boot_download.v]
// Function
// - Download is over once the receive line has idled for the rate's timeout, four character times at the fast and slow rates.
// - Idle end detection is armed only after the sync character, and before it the loader waits forever.
// - Reset held with both mode inputs low puts the device in EPROM emulation mode.
// - In emulation the data pins drive when the emulated output enable is low and float as inputs when high.
// - The boot ROM map bit reads 0 and is locked in normal modes, resets to 1 and is writable in bootstrap mode.
// - While the boot ROM is mapped its address range selects the boot ROM over the user memory.
// - The transmitter is double buffered, so a queued character ends about two character times after its write.
// - Every received download character is echoed, starting a little over one character time later, except one arriving while the holding register stays full.
// - The sync character chooses between the fast and the slow rate, both with a four character timeout.
// - Alternate sync characters pick three more rates with 4.9, 17.3 and 13 character timeouts, all clock scaled.
// - Any length from zero to 512 bytes is taken, ending on the idle timeout.
// - A zero first character, at any rate but the 4.9 character one, skips the load and starts execution at the EEPROM start.
// - A load ending on the idle timeout starts execution at the start of RAM.
// - At bootstrap start the transmitter sends one break character.
`timescale 1ns/1ps
`default_nettype none
`include "serial_boot_defines.vh"

module serial_boot_download (
  input wire ref_clk,
  input wire sys_rst,
  input wire mode_a,
  input wire mode_b,
  input wire rxd,
  output reg txd_out,
  output reg txd_oe,
  input wire port_b_top_pin,
  input wire [7:0] data_port_in,
  output reg [7:0] data_port_out,
  output reg [7:0] data_port_oe,
  input wire [7:0] eprom_rd_data,
  output reg [7:0] emu_wr_data,
  output reg emu_mode,
  input wire map_wr_en,
  input wire map_wr_data,
  output reg boot_rom_map_enable,
  input wire [15:0] cpu_addr,
  output reg boot_rom_sel,
  input wire [8:0] ram_rd_addr,
  output wire [7:0] ram_rd_data,
  output reg boot_mode,
  output reg [2:0] rate_sel,
  output reg [9:0] load_count,
  output reg loading,
  output reg exec_go,
  output reg [15:0] exec_addr
);

  // ----------------------------------------
  // Rate lookups
  // ----------------------------------------
  function [11:0] rate_bits;
    input [2:0] rate;
    begin
      case (rate)
        `RATE_SLOW: rate_bits = `DIV_SLOW;
        `RATE_ALT_A: rate_bits = `DIV_ALT_A;
        `RATE_ALT_B: rate_bits = `DIV_ALT_B;
        `RATE_ALT_C: rate_bits = `DIV_ALT_C;
        default: rate_bits = `DIV_FAST;
      endcase
    end
  endfunction

  function [7:0] rate_timeout;
    input [2:0] rate;
    begin
      case (rate)
        `RATE_SLOW: rate_timeout = `TMO_SLOW;
        `RATE_ALT_A: rate_timeout = `TMO_ALT_A;
        `RATE_ALT_B: rate_timeout = `TMO_ALT_B;
        `RATE_ALT_C: rate_timeout = `TMO_ALT_C;
        default: rate_timeout = `TMO_FAST;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [3:0] pin_m_r;
  reg [3:0] pin_s_r;
  wire mode_a_s = pin_s_r[0];
  wire mode_b_s = pin_s_r[1];
  wire rxd_s = pin_s_r[2];
  wire oe_pin_s = pin_s_r[3];
  reg [7:0] dport_m_r;
  reg [7:0] dport_s_r;

  always @(posedge ref_clk) begin
    pin_m_r <= {port_b_top_pin, rxd, mode_b, mode_a};
    pin_s_r <= pin_m_r;
    dport_m_r <= data_port_in;
    dport_s_r <= dport_m_r;
  end

  wire strap_boot = !mode_a_s && !mode_b_s;

  // ----------------------------------------
  // Mode straps, boot ROM map, emulation
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      boot_mode <= strap_boot;
      boot_rom_map_enable <= strap_boot;
      boot_rom_sel <= 1'b0;
    end else begin
      if (boot_mode && map_wr_en) begin
        boot_rom_map_enable <= map_wr_data;
      end
      // User memory at the same addresses stays hidden while mapped
      boot_rom_sel <= boot_rom_map_enable && (cpu_addr >= `BOOT_ROM_BASE) && (cpu_addr <= `BOOT_ROM_LAST);
    end
  end

  // Runs during reset on purpose: emulation exists only while reset is held
  always @(posedge ref_clk) begin
    emu_mode <= sys_rst && strap_boot;
    data_port_out <= eprom_rd_data;
    data_port_oe <= {8{sys_rst && strap_boot && !oe_pin_s}};
    emu_wr_data <= dport_s_r;
  end

  // ----------------------------------------
  // Bit rate divider
  // ----------------------------------------
  reg [11:0] div_r;
  wire [11:0] bit_cycles = rate_bits(rate_sel);
  wire bit_tick = (div_r == 12'h000);

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      div_r <= 12'h000;
    end else if (bit_tick) begin
      div_r <= bit_cycles - 12'h001;
    end else begin
      div_r <= div_r - 12'h001;
    end
  end

  // ----------------------------------------
  // Loader sequence
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_SYNC = 3'h1;
  localparam ST_MEASURE = 3'h2;
  localparam ST_SKIP = 3'h3;
  localparam ST_LOAD = 3'h4;
  localparam ST_DONE = 3'h5;

  reg [2:0] state_r;
  reg [15:0] sync_cnt_r;
  reg [7:0] idle_bits_r;
  reg line_d_r;
  reg break_pend_r;
  wire rx_valid;
  wire [7:0] rx_data;
  wire rx_busy;
  wire ram_we = rx_valid && (state_r == ST_LOAD) && (load_count < `RAM_BYTES);
  wire [15:0] skip_len = {4'h0, bit_cycles} * 16'h0009 + {5'h00, bit_cycles[11:1]};

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      sync_cnt_r <= 16'h0000;
      idle_bits_r <= 8'h00;
      line_d_r <= 1'b1;
      rate_sel <= `RATE_FAST;
      load_count <= 10'h000;
      loading <= 1'b0;
      exec_go <= 1'b0;
      exec_addr <= 16'h0000;
    end else begin
      line_d_r <= rxd_s;
      case (state_r)
        ST_IDLE: begin
          if (boot_mode) begin
            state_r <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          // No time limit here: the host may start whenever it likes
          if (line_d_r && !rxd_s) begin
            state_r <= ST_MEASURE;
            sync_cnt_r <= 16'h0000;
          end
        end
        ST_MEASURE: begin
          sync_cnt_r <= sync_cnt_r + 16'h0001;
          if (sync_cnt_r[11:0] >= `THR_ZERO) begin
            state_r <= ST_DONE;
            exec_addr <= `EEPROM_START;
            exec_go <= 1'b1;
          end else if (rxd_s) begin
            // Low time of the first pulse tells the sync character and rate apart
            state_r <= ST_SKIP;
            if (sync_cnt_r[11:0] < `THR_B_FAST) begin
              rate_sel <= `RATE_FAST;
            end else if (sync_cnt_r[11:0] < `THR_C_B) begin
              rate_sel <= `RATE_ALT_B;
            end else if (sync_cnt_r[11:0] < `THR_A_C) begin
              rate_sel <= `RATE_ALT_C;
            end else if (sync_cnt_r[11:0] < `THR_SLOW_A) begin
              rate_sel <= `RATE_ALT_A;
            end else begin
              rate_sel <= `RATE_SLOW;
            end
          end
        end
        ST_SKIP: begin
          // Let the rest of the sync character pass before taking data
          sync_cnt_r <= sync_cnt_r + 16'h0001;
          if (sync_cnt_r >= skip_len) begin
            state_r <= ST_LOAD;
            loading <= 1'b1;
            idle_bits_r <= 8'h00;
          end
        end
        ST_LOAD: begin
          if (ram_we) begin
            load_count <= load_count + 10'h001;
          end
          if (rx_busy || !rxd_s) begin
            idle_bits_r <= 8'h00;
          end else if (bit_tick) begin
            idle_bits_r <= idle_bits_r + 8'h01;
          end
          if (idle_bits_r >= rate_timeout(rate_sel)) begin
            state_r <= ST_DONE;
            loading <= 1'b0;
            exec_addr <= `RAM_START;
            exec_go <= 1'b1;
          end
        end
        ST_DONE: begin
          state_r <= ST_DONE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  serial_rx u_rx (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .enable(state_r == ST_LOAD),
    .rxd_s(rxd_s),
    .bit_cycles(bit_cycles),
    .byte_valid(rx_valid),
    .byte_data(rx_data),
    .busy(rx_busy),
    // Framing errors are not acted on: the loader stores whatever byte arrives
    .frame_err()
  );

  boot_ram u_ram (
    .ref_clk(ref_clk),
    .wr_en(ram_we),
    .wr_addr(load_count[8:0]),
    .wr_data(rx_data),
    .rd_addr(ram_rd_addr),
    .rd_data(ram_rd_data)
  );

  // ----------------------------------------
  // Double buffered transmitter, open drain line
  // ----------------------------------------
  reg [7:0] hold_r;
  reg hold_full_r;
  reg [8:0] shift_r;
  reg [3:0] shift_cnt_r;
  wire load_shift = bit_tick && (shift_cnt_r == 4'h0);
  wire echo_take = rx_valid && (state_r == ST_LOAD) && (!hold_full_r || load_shift);

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      hold_r <= 8'h00;
      hold_full_r <= 1'b0;
      shift_r <= 9'h1ff;
      shift_cnt_r <= 4'h0;
      break_pend_r <= 1'b0;
      txd_out <= 1'b0;
      txd_oe <= 1'b0;
    end else begin
      if (state_r == ST_IDLE && boot_mode) begin
        break_pend_r <= 1'b1;
      end
      if (bit_tick) begin
        if (shift_cnt_r != 4'h0) begin
          txd_oe <= !shift_r[0];
          shift_r <= {1'b1, shift_r[8:1]};
          shift_cnt_r <= shift_cnt_r - 4'h1;
        end else if (hold_full_r) begin
          // Shifter takes the queued byte; the holding register frees at once
          txd_oe <= 1'b1;
          shift_r <= {1'b1, hold_r};
          shift_cnt_r <= `CHAR_BITS - 4'h1;
          hold_full_r <= 1'b0;
        end else if (break_pend_r) begin
          txd_oe <= 1'b1;
          shift_r <= 9'h000;
          shift_cnt_r <= `CHAR_BITS - 4'h1;
          break_pend_r <= 1'b0;
        end else begin
          txd_oe <= 1'b0;
        end
      end
      // Set wins over the clear above; a byte arriving while full is echoed only if the shifter takes the queued byte that cycle
      if (echo_take) begin
        hold_r <= rx_data;
        hold_full_r <= 1'b1;
      end
    end
  end

endmodule // serial_boot_download

`default_nettype wire

// [hdl/serial_rx.v]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Async receiver, 8N1, line already synchronised
// ----------------------------------------
module serial_rx (
  input wire ref_clk,
  input wire sys_rst,
  input wire enable,
  input wire rxd_s,
  input wire [11:0] bit_cycles,
  output reg byte_valid,
  output reg [7:0] byte_data,
  output reg busy,
  output reg frame_err
);

  localparam S_IDLE = 2'h0;
  localparam S_START = 2'h1;
  localparam S_DATA = 2'h2;
  localparam S_STOP = 2'h3;

  reg [1:0] state_r;
  reg [11:0] cnt_r;
  reg [2:0] bit_r;
  reg [7:0] sh_r;
  reg line_d_r;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      cnt_r <= 12'h000;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      line_d_r <= 1'b1;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      busy <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      line_d_r <= rxd_s;
      byte_valid <= 1'b0;
      case (state_r)
        S_IDLE: begin
          // A line held low gives no edge, so it never starts a character
          if (enable && line_d_r && !rxd_s) begin
            state_r <= S_START;
            cnt_r <= {1'b0, bit_cycles[11:1]};
            busy <= 1'b1;
          end
        end
        S_START: begin
          if (cnt_r == 12'h000) begin
            if (rxd_s) begin
              state_r <= S_IDLE;
              busy <= 1'b0;
            end else begin
              state_r <= S_DATA;
              cnt_r <= bit_cycles - 12'h001;
              bit_r <= 3'h0;
            end
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        S_DATA: begin
          if (cnt_r == 12'h000) begin
            sh_r <= {rxd_s, sh_r[7:1]};
            cnt_r <= bit_cycles - 12'h001;
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7) begin
              state_r <= S_STOP;
            end
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        S_STOP: begin
          if (cnt_r == 12'h000) begin
            state_r <= S_IDLE;
            busy <= 1'b0;
            byte_valid <= 1'b1;
            byte_data <= sh_r;
            frame_err <= !rxd_s;
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule // serial_rx

`default_nettype wire
